// ---- common/simdl_pkg.sv ----
// simdl_pkg: constants and types shared by the lane datapath files.
// assumes operands arrive from a register file synchronous to clk.
package simdl_pkg;

  localparam int VEC_W = 128;
  localparam int DW_W = 64;
  localparam int LANE_MAX = 16;
  localparam int F32_LANES = 4;

  // element size codes
  localparam logic [1:0] SZ_8 = 2'h0;
  localparam logic [1:0] SZ_16 = 2'h1;
  localparam logic [1:0] SZ_32 = 2'h2;
  localparam logic [1:0] SZ_64 = 2'h3;
  localparam logic [6:0] BASE_LANE_W = 7'h08;

  // status word layout
  localparam int FP_STATUS_CONTROL_REG_W = 32;
  localparam int SAT_FLAG_BIT = 27;

  // single float fields
  localparam logic [31:0] F32_SIGN = 32'h8000_0000;
  localparam logic [7:0] F32_EXP_MAX = 8'hff;
  localparam logic [7:0] F32_EXP_TOP = 8'hfe;
  localparam logic [7:0] F32_ALIGN_MAX = 8'h18;

  // cycles from a taken request to its answer
  localparam int RESULT_LATENCY = 1;

  typedef enum logic [4:0] {
    OP_CMP,
    OP_XOR,
    OP_COPY,
    OP_NOT,
    OP_ORN,
    OP_OR,
    OP_OR_IMM,
    OP_TEST,
    OP_ABA,
    OP_ABAL,
    OP_ABD,
    OP_ABDL,
    OP_ABS,
    OP_ABS_SAT,
    OP_ADD,
    OP_ADD_SAT,
    OP_ADDL,
    OP_ADDW
  } simdl_op_t;

  typedef enum logic [2:0] {
    CMP_EQ,
    CMP_GE,
    CMP_GT,
    CMP_LE,
    CMP_LT
  } simdl_cmp_t;

endpackage

// ---- design/simdl_f32_add.sv ----
// simdl_f32_add: one single-float lane adder, combinational.
// assumes round toward zero and flush of subnormals are acceptable.
`timescale 1ns/1ps
module simdl_f32_add
  import simdl_pkg::*;
(
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire logic sub,
  output logic [31:0] sum
);

  logic [31:0] bb;
  logic [31:0] x;
  logic [31:0] y;
  logic [7:0] ex;
  logic [7:0] ey;
  logic [7:0] ed;
  logic [24:0] mx;
  logic [24:0] my;
  logic [24:0] s;
  logic [24:0] sn;
  logic [7:0] lz;

  always_comb
  begin
    bb = {b[31] ^ sub, b[30:0]};
    if (a[30:0] >= bb[30:0])
    begin
      x = a;
      y = bb;
    end
    else
    begin
      x = bb;
      y = a;
    end
    ex = x[30:23];
    ey = y[30:23];
    // subnormal inputs count as zero to keep the aligner small
    mx = (ex != 8'h00) ? {2'b01, x[22:0]} : '0;
    my = (ey != 8'h00) ? {2'b01, y[22:0]} : '0;
    ed = ex - ey;
    my = (ed > F32_ALIGN_MAX) ? '0 : (my >> ed);
    s = (x[31] == y[31]) ? (mx + my) : (mx - my);
    lz = 8'h00;
    for (int i = 0; i < 24; i++)
    begin
      if (s[i])
      begin
        lz = 8'(23 - i);
      end
    end
    sn = s << lz;
    if (ex == F32_EXP_MAX)
    begin
      sum = x;
    end
    else if (s == '0)
    begin
      sum = '0;
    end
    else if (s[24])
    begin
      if (ex == F32_EXP_TOP)
      begin
        sum = {x[31], F32_EXP_MAX, 23'h00_0000};
      end
      else
      begin
        sum = {x[31], ex + 8'h01, s[23:1]};
      end
    end
    else if (lz >= ex)
    begin
      sum = {x[31], 31'h0000_0000};
    end
    else
    begin
      sum = {x[31], ex - lz, sn[22:0]};
    end
  end

endmodule

// ---- design/simdl_lanes.sv ----
// simdl_lanes: lane-wise compare, bitwise and add/abs datapath.
// assumes one request per cycle; answer one cycle later, no stall.
//
// Contract
// - compare writes all-ones lane when condition holds, else zeros.
// - eq, ge, gt against register or zero; le, lt only against zero.
// - eq on 8/16/32 int and float; ordered zero form signed or float.
// - compare mask lane is as wide as the operand lane.
// - xor writes bitwise exclusive-or of both sources.
// - copy moves the source register unchanged.
// - not writes the complement of every source bit.
// - or-not writes first source or complement of second.
// - or-immediate ors replicated immediate into destination in place.
// - immediate byte sits in a 16 or 32 bit lane pattern.
// - or writes inclusive or of both sources.
// - bit test writes ones where lane and is nonzero.
// - absdiff-accumulate adds lane absolute difference into destination.
// - absdiff writes lane magnitude of difference; long form widens.
// - long absdiff-accumulate widens 64-bit sources into quad destination.
// - integer abs gives magnitude; float abs clears only sign bit.
// - saturating abs clamps to maximum and sets sticky flag.
// - plain add on 8 to 64 bit integer and float lanes.
// - long add widens both sources; wide add widens second only.
// - sticky flag is status bit 27 and stays set.
`timescale 1ns/1ps
module simdl_lanes
  import simdl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire simdl_op_t op_code,
  input wire simdl_cmp_t cmp_cond,
  input wire logic [1:0] elem_size,
  input wire logic elem_signed,
  input wire logic elem_float,
  input wire logic quad,
  input wire logic cmp_zero,
  input wire logic cond_pass,
  input wire logic [7:0] imm_byte,
  input wire logic [1:0] imm_pos,
  input wire logic [VEC_W-1:0] src_first,
  input wire logic [VEC_W-1:0] src_second,
  input wire logic [VEC_W-1:0] dest_old,
  input wire logic sat_clear,
  output logic res_valid,
  output logic res_write,
  output logic res_fault,
  output logic [VEC_W-1:0] res_data,
  output logic sticky_saturation_flag,
  output logic [FP_STATUS_CONTROL_REG_W-1:0] fp_status_control_reg
);

  typedef struct packed {
    logic done;
    logic wr;
    logic fault;
    logic sat;
    logic [VEC_W-1:0] data;
  } simdl_state_t;

  simdl_state_t st_reg;
  simdl_state_t st_next;
  logic [F32_LANES*32-1:0] fsum;

  genvar g;
  generate
    for (g = 0; g < F32_LANES; g++)
    begin : g_fadd
      simdl_f32_add u_fadd (
        .a(src_first[32*g +: 32]),
        .b(src_second[32*g +: 32]),
        .sub(op_code == OP_ABD),
        .sum(fsum[32*g +: 32])
      );
    end
  endgenerate

  // sign or zero extension of the low w bits to 66 bits
  function automatic logic [65:0] ext(input logic [63:0] v, input logic [6:0] w,
                                      input logic sg);
    logic [65:0] m;
    logic [65:0] r;
    m = ~({66{1'b1}} << w);
    r = {2'b00, v} & m;
    if (sg && r[w - 7'h01])
    begin
      r = r | ~m;
    end
    return r;
  endfunction

  // float order key; zeros of either sign share one key
  function automatic logic [31:0] fkey(input logic [31:0] x);
    logic [31:0] z;
    z = (x[30:0] == 31'h0000_0000) ? 32'h0000_0000 : x;
    return z[31] ? ~z : (z | F32_SIGN);
  endfunction

  function automatic logic is_nan(input logic [31:0] x);
    return (x[30:23] == F32_EXP_MAX) && (x[22:0] != 23'h00_0000);
  endfunction

  function automatic logic cmp_hit(input logic [65:0] a, input logic [65:0] b,
                                   input simdl_cmp_t c);
    logic h;
    case (c)
      CMP_EQ: h = (a == b);
      CMP_GE: h = ($signed(a) >= $signed(b));
      CMP_GT: h = ($signed(a) > $signed(b));
      CMP_LE: h = ($signed(a) <= $signed(b));
      CMP_LT: h = ($signed(a) < $signed(b));
      default: h = 1'b0;
    endcase
    return h;
  endfunction

  function automatic logic op_legal(input simdl_op_t op, input simdl_cmp_t c,
                                    input logic [1:0] sz, input logic sg,
                                    input logic fl, input logic zr);
    logic ok;
    ok = 1'b1;
    case (op)
      OP_XOR, OP_COPY, OP_NOT, OP_ORN, OP_OR, OP_OR_IMM:
        ok = 1'b1;
      OP_CMP:
      begin
        if ((c == CMP_LE || c == CMP_LT) && !zr)
        begin
          ok = 1'b0;
        end
        if (sz == SZ_64 || (fl && sz != SZ_32))
        begin
          ok = 1'b0;
        end
        if (zr && c != CMP_EQ && !sg && !fl)
        begin
          ok = 1'b0;
        end
      end
      OP_TEST, OP_ABA, OP_ABAL, OP_ABDL, OP_ADDL, OP_ADDW:
        ok = !fl && sz != SZ_64;
      OP_ABD:
        ok = sz != SZ_64 && (!fl || sz == SZ_32);
      OP_ABS:
        ok = sz != SZ_64 && (fl ? sz == SZ_32 : sg);
      OP_ABS_SAT:
        ok = sz != SZ_64 && sg && !fl;
      OP_ADD:
        ok = !fl || sz == SZ_32;
      OP_ADD_SAT:
        ok = !fl;
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction

  always_comb
  begin
    logic [VEC_W-1:0] res;
    logic sat_hit;
    logic longf;
    logic [6:0] iw;
    logic [6:0] ow;
    logic [6:0] aw;
    logic [65:0] msk;
    logic [65:0] smax;
    logic [65:0] smin;
    logic [65:0] ea;
    logic [65:0] eb;
    logic [65:0] ed;
    logic [65:0] t;
    logic [65:0] r;
    logic [15:0] p16;
    logic [31:0] p32;
    logic [31:0] fl;
    int vlen;
    ea = '0;
    eb = '0;
    ed = '0;
    t = '0;
    r = '0;
    fl = '0;
    res = '0;
    sat_hit = 1'b0;
    longf = (op_code == OP_ABAL) || (op_code == OP_ABDL) ||
            (op_code == OP_ADDL) || (op_code == OP_ADDW);
    iw = BASE_LANE_W << elem_size;
    ow = longf ? (iw << 1) : iw;
    aw = (longf && op_code != OP_ADDW) ? iw : ow;
    msk = ~({66{1'b1}} << ow);
    smax = msk >> 1;
    smin = ~smax;
    vlen = (quad || longf) ? VEC_W : DW_W;
    p16 = imm_pos[0] ? {imm_byte, 8'h00} : {8'h00, imm_byte};
    p32 = {24'h00_0000, imm_byte} << {imm_pos, 3'b000};
    case (op_code)
      OP_XOR: res = src_first ^ src_second;
      OP_COPY: res = src_first;
      OP_NOT: res = ~src_first;
      OP_ORN: res = src_first | ~src_second;
      OP_OR: res = src_first | src_second;
      OP_OR_IMM:
        res = dest_old | ((elem_size == SZ_8 || elem_size == SZ_16) ?
                          {8{p16}} : {4{p32}});
      default:
      begin
        for (int i = 0; i < LANE_MAX; i++)
        begin
          if ((i + 1) * int'(ow) <= vlen)
          begin
            ea = ext(64'(src_first >> (int'(aw) * i)), aw, elem_signed);
            eb = ext(64'(src_second >> (int'(iw) * i)), longf ? iw : ow, elem_signed);
            ed = ext(64'(dest_old >> (int'(ow) * i)), ow, elem_signed);
            fl = fsum[32 * (i % F32_LANES) +: 32];
            r = '0;
            case (op_code)
              OP_CMP:
              begin
                if (elem_float)
                begin
                  t = cmp_zero ? '0 : eb;
                  r = (!is_nan(ea[31:0]) && !is_nan(t[31:0]) &&
                       cmp_hit({34'h0, fkey(ea[31:0])}, {34'h0, fkey(t[31:0])}, cmp_cond))
                      ? msk : '0;
                end
                else
                begin
                  r = cmp_hit(ea, cmp_zero ? '0 : eb, cmp_cond) ? msk : '0;
                end
              end
              OP_TEST: r = ((ea & eb & msk) != '0) ? msk : '0;
              OP_ABD, OP_ABDL, OP_ABA, OP_ABAL:
              begin
                t = ea - eb;
                r = $signed(t) < 0 ? -t : t;
                if (op_code == OP_ABA || op_code == OP_ABAL)
                begin
                  r = r + ed;
                end
                if (elem_float)
                begin
                  r = {34'h0, fl & ~F32_SIGN};
                end
              end
              OP_ABS, OP_ABS_SAT:
              begin
                r = $signed(ea) < 0 ? -ea : ea;
                if (elem_float)
                begin
                  r = {34'h0, ea[31:0] & ~F32_SIGN};
                end
                if (op_code == OP_ABS_SAT && $signed(r) > $signed(smax))
                begin
                  r = smax;
                  sat_hit = 1'b1;
                end
              end
              OP_ADD, OP_ADDL, OP_ADDW: r = elem_float ? {34'h0, fl} : ea + eb;
              OP_ADD_SAT:
              begin
                r = ea + eb;
                if (elem_signed && $signed(r) > $signed(smax))
                begin
                  r = smax;
                  sat_hit = 1'b1;
                end
                else if (elem_signed && $signed(r) < $signed(smin))
                begin
                  r = smin;
                  sat_hit = 1'b1;
                end
                else if (!elem_signed && r > msk)
                begin
                  r = msk;
                  sat_hit = 1'b1;
                end
              end
              default: r = '0;
            endcase
            res = res | (VEC_W'(r[63:0] & msk[63:0]) << (int'(ow) * i));
          end
        end
      end
    endcase
    if (!quad && !longf)
    begin
      res[VEC_W-1:DW_W] = '0;
    end

    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.wr = 1'b0;
    st_next.fault = 1'b0;
    // clear first so a same-cycle saturation wins
    if (sat_clear)
    begin
      st_next.sat = 1'b0;
    end
    if (op_valid)
    begin
      st_next.done = 1'b1;
      if (!op_legal(op_code, cmp_cond, elem_size, elem_signed, elem_float, cmp_zero))
      begin
        st_next.fault = 1'b1;
      end
      else if (cond_pass)
      begin
        st_next.wr = 1'b1;
        st_next.data = res;
        if (sat_hit)
        begin
          st_next.sat = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  assign res_valid = st_reg.done;
  assign res_write = st_reg.wr;
  assign res_fault = st_reg.fault;
  assign res_data = st_reg.data;
  assign sticky_saturation_flag = st_reg.sat;
  assign fp_status_control_reg = FP_STATUS_CONTROL_REG_W'(st_reg.sat) << SAT_FLAG_BIT;

endmodule

// ---- testbench/simdl_issue_model.sv ----
// simdl_issue_model: destination register of the issuing core's file.
// assumes a written result is committed in the cycle it is offered.
`timescale 1ns/1ps
module simdl_issue_model
  import simdl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic res_write,
  input wire logic [VEC_W-1:0] res_data,
  output logic [VEC_W-1:0] dest_old
);
  logic [VEC_W-1:0] dest_reg;
  // forwarding, so back-to-back accumulates read the newest value
  assign dest_old = res_write ? res_data : dest_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      dest_reg <= '0;
    else if (res_write)
      dest_reg <= res_data;
  end
endmodule

// ---- testbench/simdl_lanes_asserts.sv ----
// simdl_lanes_asserts: port-level properties of the lane datapath.
// assumes it is bound to simdl_lanes and sees only its ports.
`timescale 1ns/1ps
module simdl_lanes_asserts
  import simdl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire simdl_op_t op_code,
  input wire simdl_cmp_t cmp_cond,
  input wire logic [1:0] elem_size,
  input wire logic elem_signed,
  input wire logic quad,
  input wire logic cmp_zero,
  input wire logic cond_pass,
  input wire logic [VEC_W-1:0] src_first,
  input wire logic [VEC_W-1:0] src_second,
  input wire logic sat_clear,
  input wire logic res_valid,
  input wire logic res_write,
  input wire logic res_fault,
  input wire logic [VEC_W-1:0] res_data,
  input wire logic sticky_saturation_flag,
  input wire logic [FP_STATUS_CONTROL_REG_W-1:0] fp_status_control_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_take(simdl_op_t o);
    clk_en && op_valid && cond_pass && quad && op_code == o;
  endsequence
  sequence s_sat8;
    s_take(OP_ADD_SAT) ##0 elem_size == SZ_8 && elem_signed
      && src_first[7:0] == 8'h7f && src_second[7:0] == 8'h01;
  endsequence
  valid_after_take_a: assert property (clk_en && op_valid |=> res_valid)
    else $error("no answer one cycle after a taken request");
  write_needs_pass_a: assert property (clk_en && op_valid && !cond_pass |=> !res_write)
    else $error("write despite failed condition");
  data_only_on_write_a: assert property ($changed(res_data) |-> res_write)
    else $error("result changed without a write");
  fault_blocks_write_a: assert property (res_fault |-> !res_write)
    else $error("refused request wrote a result");
  le_needs_zero_a: assert property (clk_en && op_valid && op_code == OP_CMP
    && cmp_cond inside {CMP_LE, CMP_LT} && !cmp_zero |=> res_fault)
    else $error("register form of le or lt accepted");
  flag_sticky_a: assert property (sticky_saturation_flag && !(clk_en && sat_clear)
    |=> sticky_saturation_flag) else $error("sticky flag dropped");
  status_bit_a: assert property (fp_status_control_reg
    == (FP_STATUS_CONTROL_REG_W'(sticky_saturation_flag) << SAT_FLAG_BIT)) else $error("status word bit wrong");
  xor_result_a: assert property (s_take(OP_XOR) |=> res_write
    && res_data == ($past(src_first) ^ $past(src_second))) else $error("xor result wrong");
  or_result_a: assert property (s_take(OP_OR) |=> res_write
    && res_data == ($past(src_first) | $past(src_second))) else $error("or result wrong");
  not_result_a: assert property (s_take(OP_NOT) ##0 src_first == src_second
    |=> res_data == ~$past(src_first)) else $error("not result wrong");
  sat_add_flag_a: assert property (s_sat8 |=> sticky_saturation_flag
    && res_data[7:0] == 8'h7f) else $error("saturating add did not clamp");
endmodule

bind simdl_lanes simdl_lanes_asserts chk (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
  .op_valid(op_valid), .op_code(op_code), .cmp_cond(cmp_cond), .elem_size(elem_size),
  .elem_signed(elem_signed), .quad(quad), .cmp_zero(cmp_zero), .cond_pass(cond_pass),
  .src_first(src_first), .src_second(src_second), .sat_clear(sat_clear),
  .res_valid(res_valid), .res_write(res_write), .res_fault(res_fault), .res_data(res_data),
  .sticky_saturation_flag(sticky_saturation_flag),
  .fp_status_control_reg(fp_status_control_reg));

// ---- testbench/simdl_lanes_tb_top.sv ----
// simdl_lanes_tb_top: self-checking bench for the lane datapath.
// assumes the issue model feeds the destination back as dest_old.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
`define R128 {$random(seed), $random(seed), $random(seed), $random(seed)}
module simdl_lanes_tb_top;
  import simdl_pkg::*;
  typedef struct packed {logic w; logic f; logic fl; logic [127:0] d;} simdl_exp_t;
  logic clk = 0, rst_b = 0, clk_en = 1, op_valid = 0, sg = 0, fl = 0, q = 1, cz = 0, cp = 1;
  logic sc = 0, exp_flag = 0, res_valid, res_write, res_fault, flag;
  simdl_op_t op = OP_XOR;
  simdl_cmp_t cc = CMP_EQ;
  logic [1:0] sz = SZ_8, ip = 0;
  logic [7:0] ib = 0;
  logic [127:0] a = 0, b = 0, e = 0, last = 0, res_data, dest_old;
  logic [31:0] fpsr;
  logic signed [15:0] x16, y16;
  int errors = 0, cmp_count = 0, seed = 84406, i, k;
  simdl_exp_t x;
  simdl_exp_t exp_q[$];
  simdl_op_t bw[6] = '{OP_XOR, OP_ORN, OP_OR, OP_COPY, OP_NOT, OP_XOR};
  always #50 clk = ~clk;
  simdl_lanes dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op), .cmp_cond(cc), .elem_size(sz), .elem_signed(sg), .elem_float(fl), .quad(q),
    .cmp_zero(cz), .cond_pass(cp), .imm_byte(ib), .imm_pos(ip), .src_first(a),
    .src_second(b), .dest_old(dest_old), .sat_clear(sc), .res_valid(res_valid),
    .res_write(res_write), .res_fault(res_fault), .res_data(res_data),
    .sticky_saturation_flag(flag), .fp_status_control_reg(fpsr));
  simdl_issue_model model (.clk(clk), .rst_b(rst_b), .res_write(res_write),
    .res_data(res_data), .dest_old(dest_old));
  task automatic tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // request stays raised; the caller has set every field beforehand
  task automatic go(input logic w, input logic f, input logic [127:0] d);
    begin
      op_valid = 1'b1;
      if (w)
        last = d;
      exp_q.push_back('{w, f, exp_flag, last});
      @(posedge clk);
      #1;
    end
  endtask
  task automatic st(input simdl_op_t o, input logic [1:0] s, input logic g);
    begin
      op = o;
      sz = s;
      sg = g;
      fl = 0;
      cp = 1;
      cz = 0;
    end
  endtask
  always @(posedge clk)
  begin
    #2;
    if (res_valid === 1'b1 && exp_q.size() == 0)
      `CHK(res_valid, 1'b0)
    else if (res_valid === 1'b1)
    begin
      x = exp_q.pop_front();
      `CHK(res_write, x.w)
      `CHK(res_fault, x.f)
      `CHK(res_data, x.d)
      `CHK(flag, x.fl)
      `CHK(fpsr[SAT_FLAG_BIT], x.fl)
    end
  end
  // 34 requests over about 56 cycles are issued; ten times that is ample
  initial
  begin
    #(100 * 600);
    errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    for (i = 0; i < 6; i++)
    begin
      st(bw[i], 2'($random(seed)), 0);
      a = `R128;
      b = (i == 3 || i == 4) ? a : `R128;
      q = (i != 5);
      case (i)
        1: e = a | ~b;
        2: e = a | b;
        3: e = a;
        4: e = ~a;
        default: e = a ^ b;
      endcase
      if (!q)
        e[127:64] = '0;
      go(1, 0, e);
    end
    q = 1;
    $display("test bitwise done");
    st(OP_OR_IMM, SZ_16, 0);
    ib = 8'ha5;
    ip = 1;
    go(1, 0, last | {8{16'ha500}});
    sz = SZ_32;
    ip = 2;
    go(1, 0, last | {4{32'h00a5_0000}});
    sz = SZ_8;
    ip = 0;
    go(1, 0, last | {8{16'h00a5}});
    $display("test immediate done");
    a = `R128;
    b = `R128;
    b[15:0] = a[15:0];
    a[47:32] = '0;
    for (i = 0; i < 5; i++)
    begin
      st(OP_CMP, SZ_16, 1);
      cc = simdl_cmp_t'(i);
      cz = (i > 2);
      for (k = 0; k < 8; k++)
      begin
        x16 = a[16*k+:16];
        y16 = cz ? 16'sh0 : b[16*k+:16];
        e[16*k+:16] = {16{(i == 0) ? x16 == y16 : (i == 1) ? x16 >= y16 :
          (i == 2) ? x16 > y16 : (i == 3) ? x16 <= y16 : x16 < y16}};
      end
      go(1, 0, e);
    end
    cz = 0;
    go(0, 1, last);
    st(OP_TEST, SZ_32, 0);
    b[63:32] = ~a[63:32];
    for (k = 0; k < 4; k++)
      e[32*k+:32] = {32{|(a[32*k+:32] & b[32*k+:32])}};
    go(1, 0, e);
    $display("test compare done");
    st(OP_ADD, SZ_8, 0);
    a = {16{8'hff}};
    b = {16{8'h01}};
    go(1, 0, '0);
    st(OP_ADD_SAT, SZ_8, 1);
    a = {16{8'h7f}};
    exp_flag = 1;
    go(1, 0, a);
    st(OP_XOR, SZ_8, 0);
    go(1, 0, a ^ b);
    sc = 1;
    exp_flag = 0;
    go(1, 0, a ^ b);
    sc = 0;
    st(OP_ADD_SAT, SZ_8, 1);
    cp = 0;
    go(0, 0, last);
    st(OP_ABS_SAT, SZ_8, 1);
    a = {16{8'h80}};
    exp_flag = 1;
    go(1, 0, {16{8'h7f}});
    st(OP_ABS, SZ_32, 1);
    fl = 1;
    a = {4{32'hc0a0_0000}};
    go(1, 0, {4{32'h40a0_0000}});
    st(OP_ABS, SZ_16, 1);
    a = {8{16'hfffd}};
    go(1, 0, {8{16'h0003}});
    st(OP_ADD_SAT, SZ_8, 0);
    a = {16{8'hff}};
    b = {16{8'h01}};
    go(1, 0, a);
    st(OP_ADD, SZ_32, 0);
    fl = 1;
    a = {4{32'h3fc0_0000}};
    b = a;
    go(1, 0, {4{32'h4040_0000}});
    st(OP_CMP, SZ_32, 0);
    fl = 1;
    cc = CMP_EQ;
    a = {4{32'h8000_0000}};
    b = '0;
    go(1, 0, '1);
    $display("test saturation done");
    a = {16{8'h03}};
    b = {16{8'h05}};
    st(OP_ABD, SZ_8, 0);
    go(1, 0, {16{8'h02}});
    st(OP_ABA, SZ_8, 0);
    go(1, 0, {16{8'h04}});
    st(OP_ABDL, SZ_8, 0);
    go(1, 0, {8{16'h0002}});
    st(OP_ABAL, SZ_8, 0);
    go(1, 0, {8{16'h0004}});
    st(OP_ADDL, SZ_8, 0);
    a = {16{8'hff}};
    b = {16{8'h01}};
    go(1, 0, {8{16'h0100}});
    st(OP_ADDW, SZ_8, 0);
    a = {8{16'h00ff}};
    b = {16{8'h02}};
    go(1, 0, {8{16'h0101}});
    $display("test arithmetic done");
    op_valid = 0;
    @(posedge clk);
    #1;
    clk_en = 0;
    op_valid = 1;
    repeat (2) @(posedge clk);
    #1;
    clk_en = 1;
    go(1, 0, {8{16'h0101}});
    op_valid = 0;
    repeat (3) @(posedge clk);
    `CHK(exp_q.size(), 0)
    $display("test enable done");
    tally_and_finish();
  end
endmodule
